// ==== verilog/clt_limit_bank.sv ====
/*
 Charger limit register bank with its word-wide two-wire slave, regulation
 target selection and processor-hot throttle. Assumes the two-wire pins are
 already synchronous to sys_clk and that open-drain wiring is outside.
*/
`timescale 1ns/10ps
`default_nettype none
module clt_limit_bank #(
    parameter logic [6:0] SLAVE_ADDR = 7'h2a  // Arbitrary value
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Two-wire serial port
    input  wire logic              smbClk,
    input  wire logic              smbDataIn,
    output logic                   smbDataOut,
    output logic                   smbDataOeN,
    // Battery and adapter status
    input  wire logic              batteryPresent,
    input  wire logic              batteryCharging,
    input  wire logic              learnRequest,
    input  wire logic [15:0]       batteryVoltageMv,
    input  wire logic [15:0]       adapterCurrentMa,
    input  wire logic [15:0]       throttleTimingControl,
    // Limits and targets
    output clt_pkg::clt_dur_t      limitDurations,
    output clt_pkg::clt_volt_t     voltTargets,
    // Processor-hot open-drain pin
    output logic                   processorHotOut,
    output logic                   processorHotOeN
);
    import clt_pkg::*;

    clt_smb_state_t state_q;
    logic           sclPrev_q;
    logic           sdaPrev_q;
    logic [3:0]     bitCnt_q;
    logic [7:0]     shift_q;
    logic [7:0]     cmd_q;
    logic [7:0]     loByte_q;
    logic [7:0]     txByte_q;
    logic           sdaLow_q;
    logic           sclRise;
    logic           sclFall;
    logic           startSeen;
    logic           stopSeen;
    logic           cmdKnown;
    logic           addrMatch;
    logic           wrEn;
    logic [15:0]    wrWord;
    logic [15:0]    rdWord;
    logic [15:0]    durSel_q;
    logic [15:0]    ceil_q;
    logic [15:0]    floor_q;
    logic [15:0]    thr_q;
    logic [15:0]    ceilIn;
    logic [15:0]    floorIn;
    logic [15:0]    thrIn;
    logic           hotActive;
    logic           trickleNow;

    // ------------------------------------------------------------
    // Line events
    // ------------------------------------------------------------
    assign sclRise   = smbClk & ~sclPrev_q;
    assign sclFall   = ~smbClk & sclPrev_q;
    assign startSeen = smbClk & sclPrev_q & sdaPrev_q & ~smbDataIn;
    assign stopSeen  = smbClk & sclPrev_q & ~sdaPrev_q & smbDataIn;
    assign addrMatch = (shift_q[7:1] == SLAVE_ADDR);
    assign wrEn      = sclFall && bitCnt_q == 4'h9 && state_q == SM_WHI;
    assign wrWord    = {shift_q, loByte_q};

    always_comb
    begin
        case (shift_q)
            CMD_CEIL, CMD_DUR, CMD_FLOOR, CMD_THR: cmdKnown = 1'b1;
            default:                               cmdKnown = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclPrev_q <= smbClk;
            sdaPrev_q <= smbDataIn;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb
    begin
        case (cmd_q)
            CMD_CEIL:  rdWord = ceil_q & CEIL_MASK;
            CMD_DUR:   rdWord = durSel_q & DUR_MASK;
            CMD_FLOOR: rdWord = floor_q & FLOOR_MASK;
            CMD_THR:   rdWord = thr_q & THR_MASK;
            default:   rdWord = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q  <= SM_IDLE;
            bitCnt_q <= 4'h0;
            shift_q  <= 8'h00;
            cmd_q    <= 8'h00;
            loByte_q <= 8'h00;
            txByte_q <= 8'h00;
            sdaLow_q <= 1'b0;
        end
        else if (startSeen)
        begin
            state_q  <= SM_ADDR;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b0;
        end
        else if (stopSeen)
        begin
            state_q  <= SM_IDLE;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b0;
        end
        else if (state_q != SM_IDLE && state_q != SM_IGNORE)
        begin
            if (sclRise && bitCnt_q != 4'h9)
            begin
                bitCnt_q <= bitCnt_q + 4'h1;
                if (bitCnt_q < 4'h8)
                    shift_q <= {shift_q[6:0], smbDataIn};
                else if (state_q == SM_RLO && smbDataIn)
                    state_q <= SM_IGNORE;
            end
            else if (sclFall)
            begin
                if (state_q == SM_RLO || state_q == SM_RHI)
                begin
                    if (bitCnt_q > 4'h0 && bitCnt_q < 4'h8)
                    begin
                        sdaLow_q <= ~txByte_q[6];
                        txByte_q <= {txByte_q[6:0], 1'b0};
                    end
                    else if (bitCnt_q == 4'h8)
                        sdaLow_q <= 1'b0;
                end
                if (bitCnt_q == 4'h8 && state_q != SM_RLO && state_q != SM_RHI)
                begin
                    case (state_q)
                        SM_ADDR: sdaLow_q <= addrMatch;
                        SM_CMD:  sdaLow_q <= cmdKnown;
                        default: sdaLow_q <= 1'b1;
                    endcase
                end
                else if (bitCnt_q == 4'h9)
                begin
                    bitCnt_q <= 4'h0;
                    sdaLow_q <= 1'b0;
                    case (state_q)
                        SM_ADDR:
                        begin
                            if (!addrMatch)
                                state_q <= SM_IGNORE;
                            else if (shift_q[0])
                            begin
                                state_q  <= SM_RLO;
                                txByte_q <= rdWord[7:0];
                                sdaLow_q <= ~rdWord[7];
                            end
                            else
                                state_q <= SM_CMD;
                        end
                        SM_CMD:
                        begin
                            cmd_q   <= shift_q;
                            state_q <= cmdKnown ? SM_WLO : SM_IGNORE;
                        end
                        SM_WLO:
                        begin
                            loByte_q <= shift_q;
                            state_q  <= SM_WHI;
                        end
                        SM_RLO:
                        begin
                            state_q  <= SM_RHI;
                            txByte_q <= rdWord[15:8];
                            sdaLow_q <= ~rdWord[15];
                        end
                        default: state_q <= SM_IGNORE;
                    endcase
                end
            end
        end
    end

    assign smbDataOut = 1'b0;
    assign smbDataOeN = ~sdaLow_q;

    // ------------------------------------------------------------
    // Limit registers
    // ------------------------------------------------------------
    assign ceilIn  = wrWord & CEIL_MASK;
    assign floorIn = wrWord & FLOOR_MASK;
    assign thrIn   = wrWord & THR_MASK;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            durSel_q <= DUR_RESET;
        else if (wrEn && cmd_q == CMD_DUR)
            durSel_q <= wrWord & DUR_MASK;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ceil_q <= CEIL_RESET;
        else if (wrEn && cmd_q == CMD_CEIL && ceilIn != 16'h0000)
            ceil_q <= (ceilIn > CEIL_MAX) ? CEIL_MAX : ceilIn;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            floor_q <= FLOOR_RESET;
        else if (wrEn && cmd_q == CMD_FLOOR)
            floor_q <= (floorIn > FLOOR_MAX) ? FLOOR_MAX : floorIn;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            thr_q <= THR_RESET;
        else if (wrEn && cmd_q == CMD_THR)
            thr_q <= (thrIn > THR_MAX) ? THR_MAX : thrIn;
    end

    // ------------------------------------------------------------
    // Durations and regulation targets
    // ------------------------------------------------------------
    assign trickleNow = batteryPresent && (batteryVoltageMv < floor_q);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            limitDurations <= '0;
            voltTargets    <= '0;
        end
        else
        begin
            limitDurations.firstTenthMs  <= T1_TENTH_MS[durSel_q[T1_LSB +: 3]];
            limitDurations.secondTenUs   <= T2_TEN_US[durSel_q[T2_LSB +: 3]];
            voltTargets.chargeLimitMv    <= ceil_q;
            voltTargets.regTargetMv      <= (trickleNow && batteryCharging)
                                            ? floor_q : ceil_q;
            voltTargets.trickleSense     <= trickleNow;
            voltTargets.trickleMode      <= trickleNow && batteryCharging;
            voltTargets.learnMode        <= learnRequest && batteryPresent
                                            && (batteryVoltageMv >= floor_q);
        end
    end

    // ------------------------------------------------------------
    // Processor-hot throttle
    // ------------------------------------------------------------
    clt_hot_timer u_hot_timer (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .overLimit (adapterCurrentMa > thr_q),
        .debSel    (throttleTimingControl[PH_DEB_LSB +: 2]),
        .minSel    (throttleTimingControl[PH_MIN_LSB +: 3]),
        .hotActive (hotActive)
    );

    assign processorHotOut = 1'b0;
    assign processorHotOeN = ~hotActive;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence ceilBigWrite;
        wrEn && cmd_q == CMD_CEIL && ceilIn > CEIL_MAX;
    endsequence

    cmd_ack_a: assert property (sclFall && bitCnt_q == 4'h8 && state_q == SM_CMD && cmdKnown
        |=> !smbDataOeN)
        else $error("known command not acknowledged");
    dur_mask_a: assert property ((durSel_q & ~DUR_MASK) == 16'h0000)
        else $error("duration register holds unused bits");
    ceil_clamp_a: assert property (ceilBigWrite |=> ceil_q == CEIL_MAX)
        else $error("ceiling not clamped");
    ceil_zero_a: assert property (wrEn && cmd_q == CMD_CEIL && ceilIn == 16'h0000
        |=> $stable(ceil_q))
        else $error("zero ceiling write changed register");
    floor_clamp_a: assert property (wrEn && cmd_q == CMD_FLOOR && floorIn > FLOOR_MAX
        |=> floor_q == FLOOR_MAX)
        else $error("floor not clamped");
    thr_clamp_a: assert property (wrEn && cmd_q == CMD_THR && thrIn > THR_MAX
        |=> thr_q == THR_MAX)
        else $error("threshold not clamped");
    thr_reset_a: assert property (!$past(reset_n) |-> thr_q == THR_RESET)
        else $error("threshold reset value wrong");
    trickle_target_a: assert property (trickleNow && batteryCharging
        |=> voltTargets.regTargetMv == $past(floor_q))
        else $error("trickle target is not the floor");
    ceil_target_a: assert property (!(trickleNow && batteryCharging)
        |=> voltTargets.regTargetMv == $past(ceil_q))
        else $error("idle target is not the ceiling");
    first_dur_a: assert property (wrEn && cmd_q == CMD_DUR && wrWord[2:0] == 3'h0
        |-> ##2 limitDurations.firstTenthMs == 10'h064)
        else $error("first-level default decode wrong");

endmodule : clt_limit_bank
`default_nettype wire

// ==== verilog/clt_pkg.sv ====
/*
 Package for the charger limit register bank: command codes, field masks,
 clamp values, reset values, duration tables, state types and carriers.
 Assumes a single 40 MHz system clock and an active-low asynchronous reset.
*/
//
// Behaviour
// - Host writes words; command code selects register
// - Duration register keeps only bits 2:0, 10:8
// - Bits 2:0 select first-level limit time
// - Bits 10:8 select second-level limit time
// - Ceiling keeps bits 14:3, 8mV steps
// - Ceiling writes above 18.304V store maximum
// - Zero ceiling write acknowledged, value kept
// - Ceiling is charge limit and regulation target
// - Floor keeps bits 13:8, 256mV steps
// - Floor writes above 13.824V store maximum
// - Floor is trickle and learn threshold
// - Trickle mode regulates to the floor
// - Threshold keeps bits 12:7, 128mA steps
// - Threshold writes above maximum store 6400mA
// - Threshold resets to 0x0c00, reads back
// - Overcurrent asserts hot output after debounce, holds
package clt_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0]  CMD_CEIL      = 8'h15;
    localparam logic [7:0]  CMD_DUR       = 8'h38;
    localparam logic [7:0]  CMD_FLOOR     = 8'h3e;
    localparam logic [7:0]  CMD_THR       = 8'h47;

    // ------------------------------------------------------------
    // Field masks, clamps and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] DUR_MASK      = 16'h0707;
    localparam logic [15:0] CEIL_MASK     = 16'h7ff8;
    localparam logic [15:0] FLOOR_MASK    = 16'h3f00;
    localparam logic [15:0] THR_MASK      = 16'h1f80;
    localparam logic [15:0] CEIL_MAX      = 16'h4780;
    localparam logic [15:0] FLOOR_MAX     = 16'h3600;
    localparam logic [15:0] THR_MAX       = 16'h1900;
    localparam logic [15:0] DUR_RESET     = 16'h0000;
    localparam logic [15:0] CEIL_RESET    = 16'h1068;
    localparam logic [15:0] FLOOR_RESET   = 16'h0a00;
    localparam logic [15:0] THR_RESET     = 16'h0c00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          T1_LSB        = 0;
    localparam int          T2_LSB        = 8;
    localparam int          PH_MIN_LSB    = 6;
    localparam int          PH_DEB_LSB    = 9;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          TICK_US       = 1;
    localparam int          TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
    localparam logic [5:0]  TICK_LAST     = 6'(TICK_CYCLES - 1);

    // First level in 0.1 ms, second level in 10 us units
    localparam logic [9:0]  T1_TENTH_MS [8] = '{10'h064, 10'h0c8, 10'h096, 10'h032,
                                                10'h00a, 10'h005, 10'h001, 10'h000};
    localparam logic [9:0]  T2_TEN_US   [8] = '{10'h001, 10'h00a, 10'h032, 10'h064,
                                                10'h01e, 10'h04b, 10'h0c8, 10'h3e8};
    // Hot output debounce and minimum hold, in microseconds
    localparam logic [13:0] PH_DEB_US   [4] = '{14'h000a, 14'h0014, 14'h0032, 14'h0064};
    localparam logic [13:0] PH_MIN_US   [8] = '{14'h000a, 14'h0014, 14'h0032, 14'h0064,
                                                14'h01f4, 14'h03e8, 14'h1388, 14'h2710};

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SM_IDLE   = 3'b000,
        SM_ADDR   = 3'b001,
        SM_CMD    = 3'b010,
        SM_WLO    = 3'b011,
        SM_WHI    = 3'b100,
        SM_RLO    = 3'b101,
        SM_RHI    = 3'b110,
        SM_IGNORE = 3'b111
    } clt_smb_state_t;

    typedef enum logic [1:0] {
        HOT_IDLE  = 2'b00,
        HOT_DEB   = 2'b01,
        HOT_HOLD  = 2'b10
    } clt_hot_state_t;

    typedef struct packed {
        logic [9:0]  firstTenthMs;
        logic [9:0]  secondTenUs;
    } clt_dur_t;

    typedef struct packed {
        logic [15:0] chargeLimitMv;
        logic [15:0] regTargetMv;
        logic        trickleSense;
        logic        trickleMode;
        logic        learnMode;
    } clt_volt_t;

endpackage : clt_pkg

// ==== verilog/clt_hot_timer.sv ====
/*
 Processor-hot timer: debounces an over-limit level, then holds the hot
 output for a programmable minimum time. Assumes synchronous inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module clt_hot_timer (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Condition and timing selects
    input  wire logic       overLimit,
    input  wire logic [1:0] debSel,
    input  wire logic [2:0] minSel,
    // Hot level
    output logic            hotActive
);
    import clt_pkg::*;

    clt_hot_state_t hotState_q;
    logic [5:0]     tickCnt_q;
    logic [13:0]    usCnt_q;
    logic           tick;

    // ------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------
    assign tick = (tickCnt_q == TICK_LAST);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            tickCnt_q <= 6'h00;
        else if (tick)
            tickCnt_q <= 6'h00;
        else
            tickCnt_q <= tickCnt_q + 6'h01;
    end

    // ------------------------------------------------------------
    // Debounce and hold
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hotState_q <= HOT_IDLE;
            usCnt_q    <= 14'h0000;
            hotActive  <= 1'b0;
        end
        else
        begin
            case (hotState_q)
                HOT_IDLE:
                begin
                    usCnt_q <= 14'h0000;
                    if (overLimit)
                        hotState_q <= HOT_DEB;
                end
                HOT_DEB:
                begin
                    if (!overLimit)
                        hotState_q <= HOT_IDLE;
                    else if (tick && (usCnt_q + 14'h0001 >= PH_DEB_US[debSel]))
                    begin
                        hotState_q <= HOT_HOLD;
                        hotActive  <= 1'b1;
                        usCnt_q    <= 14'h0000;
                    end
                    else if (tick)
                        usCnt_q <= usCnt_q + 14'h0001;
                end
                HOT_HOLD:
                begin
                    if (usCnt_q >= PH_MIN_US[minSel] && !overLimit)
                    begin
                        hotState_q <= HOT_IDLE;
                        hotActive  <= 1'b0;
                    end
                    else if (tick && usCnt_q != 14'h3fff)
                        usCnt_q <= usCnt_q + 14'h0001;
                end
                default:
                begin
                    hotState_q <= HOT_IDLE;
                    hotActive  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    hot_debounce_a: assert property ($rose(hotActive) |-> $past(overLimit))
        else $error("hot output rose without over-limit");
    hot_hold_a: assert property ($fell(hotActive) |-> $past(usCnt_q) >= PH_MIN_US[$past(minSel)])
        else $error("hot output released before minimum hold");

endmodule : clt_hot_timer
`default_nettype wire

// ==== tb/clt_smb_host.sv ====
/*
 Host model for the two-wire word protocol: write-word and read-word tasks.
 Assumes the data line is resolved outside, with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module clt_smb_host #(
    parameter logic [6:0] ADDR = 7'h2a  // Arbitrary value
) (
    // Clock and bus lines
    input  wire logic sys_clk,
    input  wire logic sdaLine,
    output logic      smbClk,
    output logic      hostSdaLow
);
    initial
    begin
        smbClk     = 1'b1;
        hostSdaLow = 1'b0;
    end
    task automatic hold();
        repeat (4) @(posedge sys_clk);
        #2;
    endtask : hold
    task automatic clk_bit(input logic b, output logic s);
        hostSdaLow = !b;  // Data moves only while clock low
        hold();
        smbClk = 1'b1;
        hold();
        s = sdaLine;
        smbClk = 1'b0;
        hold();
    endtask : clk_bit
    task automatic xbyte(input logic [7:0] v, inout logic ok, output logic [7:0] r);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(v[i], r[i]);
        end
        clk_bit(1'b1, s);
        ok &= !s;
    endtask : xbyte
    task automatic start();
        hostSdaLow = 1'b0;
        hold();
        smbClk = 1'b1;
        hold();
        hostSdaLow = 1'b1;
        hold();
        smbClk = 1'b0;
        hold();
    endtask : start
    task automatic stop();
        hostSdaLow = 1'b1;
        hold();
        smbClk = 1'b1;
        hold();
        hostSdaLow = 1'b0;
        hold();
    endtask : stop
    task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
        logic [7:0] r;
        ok = 1'b1;
        start();
        xbyte({ADDR, 1'b0}, ok, r);  // Slave address with write bit; command code follows
        xbyte(cmd, ok, r);
        xbyte(d[7:0], ok, r);
        xbyte(d[15:8], ok, r);
        stop();
    endtask : wr_word
    task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
        logic [7:0] r;
        logic       s;
        ok = 1'b1;
        start();
        xbyte({ADDR, 1'b0}, ok, r);
        xbyte(cmd, ok, r);
        start();
        xbyte({ADDR, 1'b1}, ok, r);
        for (int i = 15; i >= 0; i--)
        begin
            clk_bit(1'b1, d[i - (i > 7 ? 8 : -8)]);
            if (i == 8) clk_bit(1'b0, s);
        end
        clk_bit(1'b1, s);
        stop();
    endtask : rd_word
endmodule : clt_smb_host
`default_nettype wire

// ==== tb/tb.sv ====
/*
 Self-checking bench for the charger limit register bank.
 Assumes the host model file is compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import clt_pkg::*;
    logic        sys_clk = 1'b0, reset_n = 1'b0, present = 1'b0, charging = 1'b0;
    logic        learn = 1'b0, ok, smbClk, hostSdaLow, sdaOeN, sdaOut, hotOeN, hotOut;
    logic [15:0] vbat = 16'h0000, iad = 16'h0000, ctl = 16'h0000, rd;
    clt_dur_t    dur;
    clt_volt_t   vt;
    wire  logic  sda = !hostSdaLow && (sdaOeN || sdaOut);
    int          bad_count = 0, check_count = 0;
    logic [39:0] rows [9] = '{{8'h38, 16'hffff, 16'h0707}, {8'h38, 16'h0000, 16'h0000},
        {8'h15, 16'hffff, 16'h4780}, {8'h15, 16'h1068, 16'h1068}, {8'h15, 16'h0007, 16'h1068},
        {8'h3e, 16'hffff, 16'h3600}, {8'h3e, 16'h0aff, 16'h0a00},  // Floor clamp and low-bit mask
        {8'h47, 16'hffff, 16'h1900}, {8'h47, 16'h0c7f, 16'h0c00}};
    logic [9:0]  t1e [8] = '{10'h064, 10'h0c8, 10'h096, 10'h032,
                             10'h00a, 10'h005, 10'h001, 10'h000};
    logic [9:0]  t2e [8] = '{10'h001, 10'h00a, 10'h032, 10'h064,
                             10'h01e, 10'h04b, 10'h0c8, 10'h3e8};
    always #12.5 sys_clk = ~sys_clk;
    clt_limit_bank uut (.sys_clk(sys_clk), .reset_n(reset_n), .smbClk(smbClk),
        .smbDataIn(sda), .smbDataOut(sdaOut), .smbDataOeN(sdaOeN), .batteryPresent(present),
        .batteryCharging(charging), .learnRequest(learn), .batteryVoltageMv(vbat),
        .adapterCurrentMa(iad), .throttleTimingControl(ctl), .limitDurations(dur),
        .voltTargets(vt), .processorHotOut(hotOut), .processorHotOeN(hotOeN));
    clt_smb_host host (.sys_clk(sys_clk), .sdaLine(sda), .smbClk(smbClk),
        .hostSdaLow(hostSdaLow));
    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : cyc
    initial
    begin
        #2_000_000;
        bad_count++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        cyc(20);
        reset_n = 1'b1;
        cyc(4);
        chk("first", 16'(t1e[0]), 16'(dur.firstTenthMs));
        chk("second", 16'(t2e[0]), 16'(dur.secondTenUs));
        host.rd_word(8'h47, rd, ok);
        chk("thr reset", 16'h0c00, rd);
        $display("test reset done");
        foreach (rows[i])
        begin
            host.wr_word(rows[i][39:32], rows[i][31:16], ok);
            chk("write ack", 16'h0001, 16'(ok));
            host.rd_word(rows[i][39:32], rd, ok);
            chk("readback", rows[i][15:0], rd);
        end
        $display("test rows done");
        for (int i = 0; i < 8; i++)
        begin
            host.wr_word(8'h38, {5'h1f, 3'(i), 5'h15, 3'(i)}, ok);
            chk("first", 16'(t1e[i]), 16'(dur.firstTenthMs));
            chk("second", 16'(t2e[i]), 16'(dur.secondTenUs));
        end
        host.wr_word(8'h20, 16'h1234, ok);
        chk("unknown nack", 16'h0000, 16'(ok));
        $display("test durations done");
        present = 1'b1;
        charging = 1'b1;
        learn = 1'b1;
        vbat = 16'd2000;
        cyc(3);
        chk("trickle target", 16'h0a00, vt.regTargetMv);
        chk("trickle", 16'h0006, 16'({vt.trickleSense, vt.trickleMode, vt.learnMode}));
        charging = 1'b0;
        cyc(3);
        chk("idle target", 16'h1068, vt.regTargetMv);
        chk("quiet", 16'h0004, 16'({vt.trickleSense, vt.trickleMode, vt.learnMode}));
        vbat = 16'd3000;
        cyc(3);
        chk("target", 16'h1068, vt.regTargetMv);
        chk("charge limit", 16'h1068, vt.chargeLimitMv);
        chk("learn", 16'h0001, 16'({vt.trickleSense, vt.trickleMode, vt.learnMode}));
        $display("test targets done");
        ctl = 16'h0240;
        iad = 16'd3072;
        cyc(500);
        chk("hot at limit", 16'h0001, 16'(hotOeN));
        iad = 16'd3200;
        cyc(750);
        chk("hot debounce", 16'h0001, 16'(hotOeN));
        for (int n = 0; n < 200 && hotOeN !== 1'b0; n++) cyc(1);
        chk("hot on", 16'h0000, 16'({hotOut, hotOeN}));
        iad = 16'd0;
        cyc(740);
        chk("hot hold", 16'h0000, 16'(hotOeN));
        for (int n = 0; n < 200 && hotOeN !== 1'b1; n++) cyc(1);
        chk("hot off", 16'h0001, 16'(hotOeN));
        $display("test hot done");
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        cyc(2);
        chk("first after reset", 16'(t1e[0]), 16'(dur.firstTenthMs));
        $display("test second reset done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
